// >>> hdl/tps_top.sv
// two-thread pipeline selector: fetch, queue, dispatch, reorder, retire, commit
`timescale 1ns/10ps
`default_nettype none
`include "tps_cfg.svh"
// Function
// - every selector alternates when both request
// - sole able thread gets every cycle
// - trace cache fetch arbitrated every clock
// - stalled thread yields fetch until refill
// - micro-op queue split between active threads
// - dispatch up to six ready micro-ops
// - wait queues ignore owning thread
// - reorder buffer half per thread
// - in-order retire per thread, alternating
// - idle retire thread gives full bandwidth
// - store commit alternates between threads
// - staging buffers half per thread
// - translation entries carry owner thread bit
module tps_top
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [1:0] fetch_req,
   input wire logic [1:0] fetch_stall,
   input wire logic [1:0] l2_fill_done,
   input wire logic [1:0] thread_active,
   input wire logic [1:0] uopq_push,
   input wire logic [1:0] uopq_pop,
   input wire logic [1:0] rename_req,
   input wire logic [1:0] rob_alloc,
   input wire logic [1:0] retire_ready,
   input wire logic [1:0] lsb_alloc,
   input wire logic [1:0] lsb_free,
   input wire logic [1:0] store_commit_req,
   input wire logic [5:0] ready_valid,
   input wire logic [5:0] ready_tid,
   input wire logic [1:0] xlat_fill_tid,
   output tps_pkg::tps_gnt_t fetch_gnt,
   output tps_pkg::tps_gnt_t rename_gnt,
   output tps_pkg::tps_gnt_t retire_gnt,
   output tps_pkg::tps_gnt_t commit_gnt,
   output tps_pkg::tps_gnt_t alloc_gnt,
   output logic [1:0] uopq_full,
   output logic [1:0] rob_full,
   output logic [1:0] lsb_full,
   output tps_pkg::tps_slot_t [5:0] dispatch_slot,
   output logic xlat_owner_tid
);
   import tps_pkg::*;
   typedef struct packed
   {
      logic [1:0] fetch_wait;
      tps_occ_t [1:0] occ;
      tps_slot_t [5:0] slot;
      logic [1:0] uopq_full;
      logic [1:0] rob_full;
      logic [1:0] lsb_full;
      logic xlat_tid;
   } tps_top_state_t;
   tps_top_state_t s_q;
   tps_top_state_t s_d;
   logic [1:0] fetch_able;
   logic [1:0] rob_take;
   logic [1:0] wait_set;
   logic [1:0] wait_clr;
   logic [1:0] uopq_in;
   logic [1:0] uopq_out;
   logic [1:0] rob_out;
   logic [1:0] lsb_in;
   logic [1:0] lsb_out;
   logic [`TPS_NUM_SEL*2-1:0] sel_req;
   tps_gnt_t [`TPS_NUM_SEL-1:0] sel_gnt;
   genvar g;

   // per-thread strobes of the fetch wait and of the partitioned buffers
   generate
      for (g = 0; g < 2; g++)
      begin : g_thr
         // refill return beats a new stall in the same cycle
         assign wait_clr[g] = l2_fill_done[g];
         assign wait_set[g] = fetch_stall[g] & ~l2_fill_done[g];
         // a thread waiting on a refill cannot use the trace cache
         assign fetch_able[g] = fetch_req[g] & ~fetch_stall[g] & ~s_q.fetch_wait[g];
         // a push into a full half is dropped, the other thread keeps moving
         assign uopq_in[g] = uopq_push[g] & ~s_q.uopq_full[g];
         assign uopq_out[g] = uopq_pop[g] & (s_q.occ[g].uopq != 5'h00);
         // reorder allocation is refused once a thread holds its half
         assign rob_take[g] = rob_alloc[g] & ~s_q.rob_full[g];
         // an entry leaves only when the registered retire grant names this thread
         assign rob_out[g] = retire_gnt.valid & (retire_gnt.tid == 1'(g)) & (s_q.occ[g].rob != 6'h00);
         assign lsb_in[g] = lsb_alloc[g] & ~s_q.lsb_full[g];
         assign lsb_out[g] = lsb_free[g] & (s_q.occ[g].lsb != 5'h00);
      end
   endgenerate

   // two request bits per selection point, in the order of the selection index
   assign sel_req = {rob_take, store_commit_req, retire_ready, rename_req, fetch_able};
   generate
      for (g = 0; g < `TPS_NUM_SEL; g++)
      begin : g_sel
         // each selection point has its own preference bit
         tps_arb u_arb
         (
            .clock(clock),
            .rst(rst),
            .req(sel_req[g*2 +: 2]),
            .gnt(sel_gnt[g])
         );
      end
   endgenerate
   assign fetch_gnt = sel_gnt[TPS_SEL_FETCH];
   assign rename_gnt = sel_gnt[TPS_SEL_RENAME];
   assign retire_gnt = sel_gnt[TPS_SEL_RETIRE];
   assign commit_gnt = sel_gnt[TPS_SEL_COMMIT];
   assign alloc_gnt = sel_gnt[TPS_SEL_ALLOC];
   always_comb
   begin
      logic [4:0] limit_q;
      logic [5:0] limit_r;
      logic [4:0] limit_l;
      limit_q = 5'(`TPS_UOPQ_ENTRIES);
      limit_r = 6'(`TPS_ROB_HALF);
      limit_l = 5'(`TPS_LSB_HALF);
      s_d = s_q;
      // queue is only split while both threads run; a lone thread may use all of it
      if (&thread_active)
      begin
         limit_q = 5'(`TPS_UOPQ_HALF);
      end
      for (int t = 0; t < 2; t++)
      begin
         if (wait_clr[t])
         begin
            s_d.fetch_wait[t] = 1'b0;
         end
         else if (wait_set[t])
         begin
            s_d.fetch_wait[t] = 1'b1;
         end
         s_d.occ[t].uopq = s_q.occ[t].uopq + 5'(uopq_in[t]) - 5'(uopq_out[t]);
         s_d.occ[t].rob = s_q.occ[t].rob + 6'(rob_take[t]) - 6'(rob_out[t]);
         s_d.occ[t].lsb = s_q.occ[t].lsb + 5'(lsb_in[t]) - 5'(lsb_out[t]);
         // flags follow the next occupancy, so the request after the last free entry is already refused
         s_d.uopq_full[t] = s_d.occ[t].uopq >= limit_q;
         s_d.rob_full[t] = s_d.occ[t].rob >= limit_r;
         s_d.lsb_full[t] = s_d.occ[t].lsb >= limit_l;
      end
      // up to six ready micro-ops leave per cycle, thread id passed through untouched
      for (int i = 0; i < `TPS_DISPATCH_WIDTH; i++)
      begin
         s_d.slot[i].valid = ready_valid[i];
         s_d.slot[i].tid = ready_tid[i];
      end
      // a fill writes the owner bit; between fills the entry keeps its owner
      if (xlat_fill_tid[0])
      begin
         s_d.xlat_tid = xlat_fill_tid[1];
      end
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end
   assign uopq_full = s_q.uopq_full;
   assign rob_full = s_q.rob_full;
   assign lsb_full = s_q.lsb_full;
   assign dispatch_slot = s_q.slot;
   assign xlat_owner_tid = s_q.xlat_tid;
endmodule // tps_top
`default_nettype wire

// >>> hdl/tps_cfg.svh
// buffer sizes, dispatch width, selector count and reset value of the two-thread pipeline selector
`ifndef TPS_CFG_SVH
`define TPS_CFG_SVH
`define TPS_UOPQ_ENTRIES 16
`define TPS_UOPQ_HALF 8
`define TPS_ROB_ENTRIES 32
`define TPS_ROB_HALF 16
`define TPS_LSB_ENTRIES 16
`define TPS_LSB_HALF 8
`define TPS_DISPATCH_WIDTH 6
`define TPS_PREF_RESET 1'b0
`define TPS_NUM_SEL 5
`endif

// >>> hdl/tps_pkg.sv
// types shared by the two-thread pipeline selector
`default_nettype none
package tps_pkg;
   // selection points, one index each
   typedef enum logic [2:0]
   {
      TPS_SEL_FETCH = 3'h0,
      TPS_SEL_RENAME = 3'h1,
      TPS_SEL_RETIRE = 3'h2,
      TPS_SEL_COMMIT = 3'h3,
      TPS_SEL_ALLOC = 3'h4
   } tps_sel_t;
   // per-thread request into one selection point
   typedef struct packed
   {
      logic [1:0] req;
   } tps_req_t;
   // grant out of one selection point
   typedef struct packed
   {
      logic valid;
      logic tid;
   } tps_gnt_t;
   // occupancy counts of the partitioned buffers, per thread
   typedef struct packed
   {
      logic [4:0] uopq;
      logic [5:0] rob;
      logic [4:0] lsb;
   } tps_occ_t;
   // dispatch slot: owning thread carried along, ignored by scheduling
   typedef struct packed
   {
      logic valid;
      logic tid;
   } tps_slot_t;
   // state of one alternating selector
   typedef struct packed
   {
      logic pref;
      tps_gnt_t gnt;
   } tps_arb_state_t;
endpackage : tps_pkg
`default_nettype wire

// >>> hdl/tps_arb.sv
// one alternating two-thread selector with registered grant
`timescale 1ns/10ps
`default_nettype none
`include "tps_cfg.svh"
module tps_arb
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [1:0] req,
   output tps_pkg::tps_gnt_t gnt
);
   import tps_pkg::*;
   tps_arb_state_t s_q;
   tps_arb_state_t s_d;
   always_comb
   begin
      s_d = s_q;
      s_d.gnt.valid = |req;
      // the next both-request grant goes to the thread not served last
      unique case (req)
         2'h1:
         begin
            s_d.gnt.tid = 1'b0;
            s_d.pref = 1'b1;
         end
         2'h2:
         begin
            s_d.gnt.tid = 1'b1;
            s_d.pref = 1'b0;
         end
         2'h3:
         begin
            s_d.gnt.tid = s_q.pref;
            s_d.pref = ~s_q.pref;
         end
         2'h0: s_d.gnt.tid = s_q.gnt.tid;
      endcase
   end
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         s_q <= '{pref: `TPS_PREF_RESET, gnt: '{valid: 1'b0, tid: 1'b0}};
      end
      else
      begin
         s_q <= s_d;
      end
   end
   assign gnt = s_q.gnt;
endmodule // tps_arb
`default_nettype wire

// >>> test/tps_properties.sv
// port-level checks on the two-thread pipeline selector
`timescale 1ns/10ps
`default_nettype none
module tps_properties
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [1:0] fetch_stall,
   input wire logic [1:0] l2_fill_done,
   input wire logic [1:0] rob_alloc,
   input wire logic [1:0] rob_full,
   input wire logic [1:0] retire_ready,
   input wire logic [1:0] store_commit_req,
   input wire logic [5:0] ready_valid,
   input wire logic [5:0] ready_tid,
   input wire logic [1:0] xlat_fill_tid,
   input wire tps_pkg::tps_gnt_t fetch_gnt,
   input wire tps_pkg::tps_gnt_t retire_gnt,
   input wire tps_pkg::tps_gnt_t commit_gnt,
   input wire tps_pkg::tps_gnt_t alloc_gnt,
   input wire tps_pkg::tps_slot_t [5:0] dispatch_slot,
   input wire logic xlat_owner_tid
);
   import tps_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_retire_alternates: assert property (
      retire_ready == 2'h3 ##1 retire_ready == 2'h3 |=> retire_gnt.tid != $past(retire_gnt.tid))
      else $error("retire grant did not alternate");
   a_retire_sole: assert property (retire_ready == 2'h2 |=> retire_gnt == 2'h3)
      else $error("sole retire thread not granted");
   a_retire_idle: assert property (retire_ready == 2'h0 |=> !retire_gnt.valid)
      else $error("retire grant without request");
   a_commit_alternates: assert property (
      store_commit_req == 2'h3 ##1 store_commit_req == 2'h3 |=> commit_gnt.tid != $past(commit_gnt.tid))
      else $error("commit grant did not alternate");
   a_commit_sole: assert property (store_commit_req == 2'h1 |=> commit_gnt == 2'h2)
      else $error("sole commit thread not granted");
   a_fetch_stall_block: assert property (
      fetch_stall[0] && !l2_fill_done[0] |=> !(fetch_gnt.valid && !fetch_gnt.tid))
      else $error("stalled thread was granted fetch");
   a_rob_full_mask: assert property (rob_full[0] && rob_alloc == 2'h1 |=> !alloc_gnt.valid)
      else $error("allocation granted to full thread");
   a_xlat_owner: assert property (xlat_fill_tid[0] |=> xlat_owner_tid == $past(xlat_fill_tid[1]))
      else $error("translation owner bit lost");
   a_xlat_hold: assert property (!xlat_fill_tid[0] |=> $stable(xlat_owner_tid))
      else $error("translation owner bit changed without a fill");
   a_retire_handover: assert property (
      retire_gnt.valid && retire_ready == 2'h3 |=> retire_gnt.tid != $past(retire_gnt.tid))
      else $error("retire served the same thread twice while both were ready");
   for (genvar i = 0; i < 6; i++)
   begin : g_slot
      a_dispatch_slot: assert property (
         1'b1 |=> dispatch_slot[i] == {$past(ready_valid[i]), $past(ready_tid[i])})
         else $error("dispatch slot not a copy of ready slot");
   end
endmodule // tps_properties
bind tps_top tps_properties u_tps_properties (.*);
`default_nettype wire

// >>> test/tps_commit_model.sv
// store commit requester: per-thread count of retired stores awaiting commit
`timescale 1ns/10ps
`default_nettype none
module tps_commit_model
(
   input wire logic clock,
   input wire logic rst,
   input wire logic load,
   input wire logic [7:0] cnt,
   input wire tps_pkg::tps_gnt_t gnt,
   output logic [1:0] req
);
   import tps_pkg::*;
   logic [3:0] c0_q, c1_q;
   assign req = {c1_q != 4'h0, c0_q != 4'h0};
   // grants land a cycle late, so a count may already be spent
   always_ff @(posedge clock or posedge rst)
      if (rst)
         {c1_q, c0_q} <= 8'h00;
      else if (load)
         {c1_q, c0_q} <= cnt;
      else if (gnt.valid && gnt.tid && c1_q != 4'h0)
         c1_q <= c1_q - 4'h1;
      else if (gnt.valid && !gnt.tid && c0_q != 4'h0)
         c0_q <= c0_q - 4'h1;
endmodule // tps_commit_model
`default_nettype wire

// >>> test/tps_top_tb_top.sv
// self-checking bench of the two-thread pipeline selector
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module tps_top_tb_top;
   import tps_pkg::*;
   logic clock = 0, rst = 1, ld = 0, xp = 0;
   logic [1:0] fr = 0, fs = 0, fd = 0, ta = 0, up = 0, uo = 0, rn = 0, ra = 0, rr = 0, la = 0, lf = 0, xt = 0;
   logic [1:0] scr, uf, rf, lfl;
   logic [5:0] rv = 0, rt = 0;
   logic [7:0] cn = 0;
   logic [11:0] es;
   logic xo;
   tps_gnt_t fg, ng, tg, cg, ag;
   tps_slot_t [5:0] ds;
   int failures = 0, cmp_count = 0, cyc_n = 0;
   tps_top u_tps_top (.clock(clock), .rst(rst), .fetch_req(fr), .fetch_stall(fs), .l2_fill_done(fd),
      .thread_active(ta), .uopq_push(up), .uopq_pop(uo), .rename_req(rn), .rob_alloc(ra), .retire_ready(rr),
      .lsb_alloc(la), .lsb_free(lf), .store_commit_req(scr), .ready_valid(rv), .ready_tid(rt),
      .xlat_fill_tid(xt), .fetch_gnt(fg), .rename_gnt(ng), .retire_gnt(tg), .commit_gnt(cg), .alloc_gnt(ag),
      .uopq_full(uf), .rob_full(rf), .lsb_full(lfl), .dispatch_slot(ds), .xlat_owner_tid(xo));
   tps_commit_model u_tps_commit_model (.clock(clock), .rst(rst), .load(ld), .cnt(cn), .gnt(cg), .req(scr));
   initial forever #10 clock = ~clock;
   always @(posedge clock) if (++cyc_n > 2000) begin failures++; final_report(); end
   task cyc(input int n);
      repeat (n) @(negedge clock);
   endtask
   task rstep(input logic [1:0] r, input logic [1:0] e);
      rr = r;
      cyc(1);
      `CHK(tg, e)
   endtask
   task final_report();
      $display("failures=%0d cmp_count=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial
   begin
      void'($urandom(25));
      cyc(16);
      rst = 0;
      rstep(2'h3, 2'h2);
      rstep(2'h3, 2'h3);
      rstep(2'h1, 2'h2);
      rstep(2'h2, 2'h3);
      rstep(2'h3, 2'h2);
      rstep(2'h0, 2'h0);
      ra = 2'h1;
      cyc(20);
      `CHK(rf, 2'h1)
      {ra, rr} = 4'h1;
      cyc(20);
      `CHK(rf, 2'h0)
      {rr, la} = 4'h1;
      cyc(12);
      `CHK(lfl, 2'h1)
      {la, lf} = 4'h1;
      cyc(12);
      `CHK(lfl, 2'h0)
      {lf, ta, up} = 6'h0d;
      cyc(12);
      `CHK(uf, 2'h1)
      {ta, up} = 4'h4;
      cyc(3);
      `CHK(uf, 2'h0)
      {fr, fs} = 4'hd;
      cyc(1);
      fs = 0;
      repeat (4) begin cyc(1); `CHK(fg, 2'h3) end
      fd = 1;
      cyc(2);
      {fd, rn} = 4'h3;
      `CHK(fg, 2'h2)
      cyc(1);
      `CHK(fg, 2'h3)
      `CHK(ng, 2'h2)
      cyc(1);
      `CHK(ng, 2'h3)
      // random traffic; the ready-slot copies are predicted from the previous cycle
      repeat (300)
      begin
         {fr, fs, fd, ta, up, uo, rn, ra, rr, la, lf, xt, rv, rt} = {$urandom, 4'($urandom)};
         for (int i = 0; i < 6; i++) {es[2*i+1], es[2*i]} = {rv[i], rt[i]};
         // the owner bit only moves on a fill strobe
         if (xt[0]) xp = xt[1];
         cn = 8'($urandom) & 8'h77 | 8'h11;
         // occasional reloads let one thread run dry while the other still commits
         ld = 3'($urandom) == 3'h0;
         cyc(1);
         `CHK(ds, es)
         `CHK(xo, xp)
      end
      ld = 0;
      cyc(20);
      `CHK(scr, 2'h0)
      final_report();
   end
endmodule // tps_top_tb_top
`default_nettype wire
